/* File: area_wait_pkg.sv */
// Package: register map and field layout for area wait control
package area_wait_pkg;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam int          ADDR_W           = 4;
	localparam logic [3:0]  AREA_WAIT_CONFIG_ADDR = 4'h0;
	localparam logic [3:0]  AREA23_TYPE_ADDR      = 4'h4;
	localparam logic [15:0] AREA_WAIT_CONFIG_RESET = 16'hFFFF;
	localparam logic [2:0]  AREA23_TYPE_RESET      = 3'h0;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int A6_LSB = 13;
	localparam int A5_LSB = 10;
	localparam int A4_LSB = 7;
	localparam int A3_LSB = 5;
	localparam int A2_LSB = 3;
	localparam int A0_LSB = 0;

	// Memory type codes for areas 2 and 3
	localparam logic [2:0] TYPE_BOTH_ORDINARY = 3'h0;
	localparam logic [2:0] TYPE_A3_SDRAM      = 3'h2;
	localparam logic [2:0] TYPE_BOTH_SDRAM    = 3'h3;

endpackage

/* File: area_wait_state_control.sv */
// Per-area wait-state configuration register and its decoded settings
`timescale 1ns/10ps

// Overview of operation
// - Sixteen-bit register, all bits read and write
// - Power-on reset loads all ones
// - Manual reset and standby keep contents
// - Area 6 code gives 0..10 first waits
// - Area 5 code gives 0..10 first waits
// - Areas 6,5 ignore wait pin at zero
// - Burst pitch 2..10 states, wait honoured above 000
// - Area 4 waits 0..10, pin ignored at 000
// - Area 3 ordinary: 0..3 waits, pin gating
// - Area 3 SDRAM: field gives CAS latency
// - Area 2 ordinary: 0..3 waits, pin gating
// - Area 0 uses eight-step code, burst too
// - Memory type selects wait or CAS meaning
module area_wait_state_control
	import area_wait_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [15:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [15:0]       rdata_o,
	output logic      [3:0]        area6_first_waits_o,
	output logic      [3:0]        area6_burst_states_o,
	output logic                   area6_wait_pin_en_o,
	output logic      [3:0]        area5_first_waits_o,
	output logic      [3:0]        area5_burst_states_o,
	output logic                   area5_wait_pin_en_o,
	output logic      [3:0]        area4_first_waits_o,
	output logic                   area4_wait_pin_en_o,
	output logic      [1:0]        area3_first_waits_o,
	output logic                   area3_wait_pin_en_o,
	output logic                   area3_sdram_o,
	output logic      [1:0]        area3_cas_latency_o,
	output logic      [1:0]        area2_first_waits_o,
	output logic                   area2_wait_pin_en_o,
	output logic                   area2_sdram_o,
	output logic      [1:0]        area2_cas_latency_o,
	output logic      [3:0]        area0_first_waits_o,
	output logic      [3:0]        area0_burst_states_o,
	output logic                   area0_wait_pin_en_o
);

	// ********************************************************************
	// Registers
	// ********************************************************************
	logic [15:0] area_wait_config_r;
	logic [2:0]  area23_memory_type_r;
	logic [2:0]  area6_wait_code;
	logic [2:0]  area5_wait_code;
	logic [2:0]  area4_wait_code;
	logic [1:0]  area3_wait_code;
	logic [1:0]  area2_wait_code;
	logic [2:0]  area0_wait_code;
	logic        a3_sdram;
	logic        a2_sdram;

	// ********************************************************************
	// Decode functions
	// ********************************************************************
	// First-cycle wait states, eight-step encoding
	function automatic logic [3:0] first_waits(input logic [2:0] code);
		unique case (code)
			3'h0: first_waits = 4'h0;
			3'h1: first_waits = 4'h1;
			3'h2: first_waits = 4'h2;
			3'h3: first_waits = 4'h3;
			3'h4: first_waits = 4'h4;
			3'h5: first_waits = 4'h6;
			3'h6: first_waits = 4'h8;
			3'h7: first_waits = 4'hA;
		endcase
	endfunction

	// Burst beats never run shorter than two states
	function automatic logic [3:0] burst_states(input logic [2:0] code);
		unique case (code)
			3'h0: burst_states = 4'h2;
			3'h1: burst_states = 4'h2;
			3'h2: burst_states = 4'h3;
			3'h3: burst_states = 4'h4;
			3'h4: burst_states = 4'h4;
			3'h5: burst_states = 4'h6;
			3'h6: burst_states = 4'h8;
			3'h7: burst_states = 4'hA;
		endcase
	endfunction

	// CAS latency from a two-bit field; codes 0 and 1 both give one
	function automatic logic [1:0] cas_latency(input logic [1:0] code);
		cas_latency = (code == 2'h0) ? 2'h1 : code;
	endfunction

	// Only the power-on reset reaches this register; manual reset and
	// standby have no port here, so contents survive them by design.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			area_wait_config_r <= AREA_WAIT_CONFIG_RESET;
		end else if (wr_i && addr_i == AREA_WAIT_CONFIG_ADDR) begin
			area_wait_config_r <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			area23_memory_type_r <= AREA23_TYPE_RESET;
		end else if (wr_i && addr_i == AREA23_TYPE_ADDR) begin
			area23_memory_type_r <= wdata_i[2:0];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			unique case (addr_i)
				AREA_WAIT_CONFIG_ADDR: rdata_o <= area_wait_config_r;
				AREA23_TYPE_ADDR: rdata_o <= {13'h0000, area23_memory_type_r};
				default: rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// ********************************************************************
	// Field decode
	// ********************************************************************
	assign area6_wait_code = area_wait_config_r[A6_LSB +: 3];
	assign area5_wait_code = area_wait_config_r[A5_LSB +: 3];
	assign area4_wait_code = area_wait_config_r[A4_LSB +: 3];
	assign area3_wait_code = area_wait_config_r[A3_LSB +: 2];
	assign area2_wait_code = area_wait_config_r[A2_LSB +: 2];
	assign area0_wait_code = area_wait_config_r[A0_LSB +: 3];

	// Reserved type codes are treated as ordinary memory
	assign a3_sdram = (area23_memory_type_r == TYPE_A3_SDRAM) ||
		(area23_memory_type_r == TYPE_BOTH_SDRAM);
	assign a2_sdram = (area23_memory_type_r == TYPE_BOTH_SDRAM);

	// Decoded outputs are registered, so they lag a write by one cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			area6_first_waits_o  <= 4'hA;
			area6_burst_states_o <= 4'hA;
			area6_wait_pin_en_o  <= 1'b1;
			area5_first_waits_o  <= 4'hA;
			area5_burst_states_o <= 4'hA;
			area5_wait_pin_en_o  <= 1'b1;
			area0_first_waits_o  <= 4'hA;
			area0_burst_states_o <= 4'hA;
			area0_wait_pin_en_o  <= 1'b1;
		end else begin
			area6_first_waits_o  <= first_waits(area6_wait_code);
			area6_burst_states_o <= burst_states(area6_wait_code);
			area6_wait_pin_en_o  <= (area6_wait_code != 3'h0);
			area5_first_waits_o  <= first_waits(area5_wait_code);
			area5_burst_states_o <= burst_states(area5_wait_code);
			area5_wait_pin_en_o  <= (area5_wait_code != 3'h0);
			area0_first_waits_o  <= first_waits(area0_wait_code);
			area0_burst_states_o <= burst_states(area0_wait_code);
			area0_wait_pin_en_o  <= (area0_wait_code != 3'h0);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			area4_first_waits_o <= 4'hA;
			area4_wait_pin_en_o <= 1'b1;
		end else begin
			area4_first_waits_o <= first_waits(area4_wait_code);
			area4_wait_pin_en_o <= (area4_wait_code != 3'h0);
		end
	end

	// In SDRAM mode the wait outputs read zero and the pin is not used
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			area3_first_waits_o <= 2'h3;
			area3_wait_pin_en_o <= 1'b1;
			area3_sdram_o       <= 1'b0;
			area3_cas_latency_o <= 2'h0;
			area2_first_waits_o <= 2'h3;
			area2_wait_pin_en_o <= 1'b1;
			area2_sdram_o       <= 1'b0;
			area2_cas_latency_o <= 2'h0;
		end else begin
			area3_sdram_o <= a3_sdram;
			area2_sdram_o <= a2_sdram;
			area3_first_waits_o <= a3_sdram ? 2'h0 : area3_wait_code;
			area3_wait_pin_en_o <= !a3_sdram &&
				(area3_wait_code != 2'h0);
			area3_cas_latency_o <= a3_sdram ?
				cas_latency(area3_wait_code) : 2'h0;
			area2_first_waits_o <= a2_sdram ? 2'h0 : area2_wait_code;
			area2_wait_pin_en_o <= !a2_sdram &&
				(area2_wait_code != 2'h0);
			area2_cas_latency_o <= a2_sdram ?
				cas_latency(area2_wait_code) : 2'h0;
		end
	end

	// ********************************************************************
	// Checks
	// ********************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_cfg_write;
		wr_i && addr_i == AREA_WAIT_CONFIG_ADDR;
	endsequence

	sequence s_type_write;
		wr_i && addr_i == AREA23_TYPE_ADDR;
	endsequence

	a_write_stores: assert property (s_cfg_write |=>
		area_wait_config_r == $past(wdata_i))
		else $error("config write not stored");
	a_read_returns: assert property (rd_i && addr_i == AREA_WAIT_CONFIG_ADDR
		|=> rdata_o == $past(area_wait_config_r))
		else $error("config read wrong");
	a_hold_value: assert property (
		!(wr_i && addr_i == AREA_WAIT_CONFIG_ADDR) |=>
		$stable(area_wait_config_r))
		else $error("config changed without write");
	a_a6_zero_pin: assert property (s_cfg_write |=> ##1
		area6_wait_pin_en_o == ($past(area6_wait_code) != 3'h0))
		else $error("area6 pin gating wrong");
	a_a6_max_wait: assert property (
		area6_wait_code == 3'h7 |=> area6_first_waits_o == 4'hA)
		else $error("area6 code 7 not 10 waits");
	a_a5_burst: assert property (
		area5_wait_code == 3'h2 |=> area5_burst_states_o == 4'h3)
		else $error("area5 burst pitch wrong");
	a_a4_pin: assert property (
		area4_wait_code == 3'h0 |=> !area4_wait_pin_en_o)
		else $error("area4 pin not ignored");
	a_a3_cas: assert property (a3_sdram && area3_wait_code == 2'h0
		|=> area3_cas_latency_o == 2'h1 && !area3_wait_pin_en_o)
		else $error("area3 cas latency wrong");
	a_a2_wait: assert property (!a2_sdram && area2_wait_code == 2'h2
		|=> area2_first_waits_o == 2'h2 && area2_wait_pin_en_o)
		else $error("area2 ordinary wait wrong");
	a_a2_cas: assert property (a2_sdram && area2_wait_code == 2'h3
		|=> area2_cas_latency_o == 2'h3)
		else $error("area2 cas latency wrong");
	a_a0_pitch: assert property (
		area0_wait_code == 3'h5 |=> area0_burst_states_o == 4'h6)
		else $error("area0 pitch wrong");

	// Reset, table spot, type flag and read checks; decoded outputs follow their code one edge later
	a_reset_ones: assert property ($rose(nrst_i) |->
		area_wait_config_r == AREA_WAIT_CONFIG_RESET)
		else $error("config not all ones after reset");
	a_a6_code_zero: assert property (
		area6_wait_code == 3'h0 |=>
		area6_first_waits_o == 4'h0 && !area6_wait_pin_en_o)
		else $error("area6 code 0 wrong");
	a_a6_burst_min: assert property (
		area6_wait_code == 3'h1 |=>
		area6_burst_states_o == 4'h2 && area6_wait_pin_en_o)
		else $error("area6 burst pitch wrong");
	a_a5_max_wait: assert property (
		area5_wait_code == 3'h7 |=>
		area5_first_waits_o == 4'hA && area5_burst_states_o == 4'hA)
		else $error("area5 code 7 wrong");
	a_a5_code_zero: assert property (
		area5_wait_code == 3'h0 |=>
		area5_first_waits_o == 4'h0 && !area5_wait_pin_en_o)
		else $error("area5 code 0 wrong");
	a_a4_six_waits: assert property (
		area4_wait_code == 3'h5 |=>
		area4_first_waits_o == 4'h6 && area4_wait_pin_en_o)
		else $error("area4 code 5 wrong");
	a_a3_ordinary: assert property (
		!a3_sdram && area3_wait_code == 2'h3 |=>
		area3_first_waits_o == 2'h3 && area3_wait_pin_en_o)
		else $error("area3 ordinary wait wrong");
	a_a3_cas_two: assert property (
		a3_sdram && area3_wait_code == 2'h2 |=> area3_cas_latency_o == 2'h2)
		else $error("area3 cas latency two wrong");
	a_a2_zero_pin: assert property (
		!a2_sdram && area2_wait_code == 2'h0 |=>
		area2_first_waits_o == 2'h0 && !area2_wait_pin_en_o)
		else $error("area2 code 0 wrong");
	a_a2_cas_one: assert property (
		a2_sdram && area2_wait_code == 2'h1 |=> area2_cas_latency_o == 2'h1)
		else $error("area2 cas latency one wrong");
	a_a0_zero_pin: assert property (
		area0_wait_code == 3'h0 |=>
		area0_burst_states_o == 4'h2 && !area0_wait_pin_en_o)
		else $error("area0 code 0 wrong");
	a_type_flags: assert property (s_type_write |=> ##1
		area2_sdram_o == ($past(area23_memory_type_r) == TYPE_BOTH_SDRAM) &&
		area3_sdram_o == ($past(area23_memory_type_r) == TYPE_A3_SDRAM ||
		$past(area23_memory_type_r) == TYPE_BOTH_SDRAM))
		else $error("memory type flags wrong");
	a_read_unmapped: assert property (
		rd_i && addr_i != AREA_WAIT_CONFIG_ADDR &&
		addr_i != AREA23_TYPE_ADDR |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_read_idle: assert property (
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data outside read cycle");

endmodule

/* File: ext_memory_model.sv */
// Far-side memory model: stretches the first cycle with its wait output
`timescale 1ns/10ps
module ext_memory_model (
	input  wire logic       wait_pin_en_i,
	input  wire logic [3:0] first_waits_i,
	input  wire logic [3:0] stretch_i,
	output logic      [4:0] total_waits_o
);
	// The memory holds its wait line for stretch_i states; the controller
	// only adds them when it samples the pin
	assign total_waits_o = {1'b0, first_waits_i}
		+ (wait_pin_en_i ? {1'b0, stretch_i} : 5'h00);
endmodule

/* File: tb_top.sv */
// Testbench: register access and decoded settings of area wait control
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %0t got %h expected %h", $time, g, e); end end
module tb_top;
	import area_wait_pkg::*;
	logic              clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [15:0]       wdata_i = '0, rdata_o, r;
	logic [3:0]        a6_fw, a6_bs, a5_fw, a5_bs, a4_fw, a0_fw, a0_bs;
	logic              a6_pe, a5_pe, a4_pe, a3_pe, a2_pe, a0_pe, a3_sd, a2_sd;
	logic [1:0]        a3_fw, a2_fw, a3_cl, a2_cl;
	logic [4:0]        tot;
	int                failures = 0, num_checks = 0;
	logic [3:0] fw[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA};
	logic [3:0] bs[8] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h8, 4'hA};
	logic [1:0] cl[4] = '{2'h1, 2'h1, 2'h2, 2'h3};
	always #20 clk_i = ~clk_i;
	area_wait_state_control area_wait_state_control_inst (.clk_i(clk_i),
		.nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .area6_first_waits_o(a6_fw),
		.area6_burst_states_o(a6_bs), .area6_wait_pin_en_o(a6_pe),
		.area5_first_waits_o(a5_fw), .area5_burst_states_o(a5_bs),
		.area5_wait_pin_en_o(a5_pe), .area4_first_waits_o(a4_fw),
		.area4_wait_pin_en_o(a4_pe), .area3_first_waits_o(a3_fw),
		.area3_wait_pin_en_o(a3_pe), .area3_sdram_o(a3_sd),
		.area3_cas_latency_o(a3_cl), .area2_first_waits_o(a2_fw),
		.area2_wait_pin_en_o(a2_pe), .area2_sdram_o(a2_sd),
		.area2_cas_latency_o(a2_cl), .area0_first_waits_o(a0_fw),
		.area0_burst_states_o(a0_bs), .area0_wait_pin_en_o(a0_pe));
	ext_memory_model ext_memory_model_inst (.wait_pin_en_i(a6_pe),
		.first_waits_i(a6_fw), .stretch_i(4'h3), .total_waits_o(tot));
	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	// Decoded outputs settle one edge after the write edge; this waits two
	task automatic settle;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic close_out;
		if (failures == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic sweep(input logic [2:0] c);
		logic [15:0] w;
		w = {c, c, c, c[1:0], c[1:0], c};
		wr_reg(AREA_WAIT_CONFIG_ADDR, w);
		settle();
		`CHK(a6_fw, fw[c])
		`CHK(a5_fw, fw[c])
		`CHK({a6_pe, a5_pe}, {2{c != 3'h0}})
		`CHK(tot, {1'b0, fw[c]} + ((c != 3'h0) ? 5'h03 : 5'h00))
		`CHK({a6_bs, a5_bs}, {bs[c], bs[c]})
		`CHK({a4_fw, a4_pe}, {fw[c], c != 3'h0})
		`CHK({a3_fw, a3_pe}, {c[1:0], c[1:0] != 2'h0})
		`CHK({a2_fw, a2_pe}, {c[1:0], c[1:0] != 2'h0})
		`CHK({a0_fw, a0_bs, a0_pe}, {fw[c], bs[c], c != 3'h0})
		rd_reg(AREA_WAIT_CONFIG_ADDR, r);
		`CHK(r, w)
	endtask
	task automatic mem_type(input logic [2:0] t, input logic [1:0] k);
		logic s3, s2;
		s3 = (t == TYPE_A3_SDRAM) || (t == TYPE_BOTH_SDRAM);
		s2 = (t == TYPE_BOTH_SDRAM);
		wr_reg(AREA23_TYPE_ADDR, {13'h0000, t});
		wr_reg(AREA_WAIT_CONFIG_ADDR, {9'h000, k, k, 3'h0});
		settle();
		`CHK({a3_sd, a2_sd}, {s3, s2})
		`CHK(a3_cl, s3 ? cl[k] : 2'h0)
		`CHK(a2_cl, s2 ? cl[k] : 2'h0)
		`CHK({a3_fw, a3_pe}, s3 ? 3'h0 : {k, k != 2'h0})
		`CHK({a2_fw, a2_pe}, s2 ? 3'h0 : {k, k != 2'h0})
		rd_reg(AREA23_TYPE_ADDR, r);
		`CHK(r, {13'h0000, t})
	endtask
	initial begin
		#(40 * 3000);
		failures++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		#1;
		`CHK({a6_fw, a6_bs, a6_pe, a3_fw, a3_sd}, 12'hAAE)
		rd_reg(AREA_WAIT_CONFIG_ADDR, r);
		`CHK(r, 16'hFFFF)
		@(posedge clk_i);
		#1;
		`CHK(rdata_o, 16'h0000)
		for (int c = 0; c < 8; c++) begin
			sweep(c[2:0]);
		end
		for (int t = 0; t < 4; t++) begin
			for (int k = 0; k < 4; k++) begin
				mem_type(t[2:0], k[1:0]);
			end
		end
		wr_reg(AREA_WAIT_CONFIG_ADDR, 16'hA5C3);
		wr_reg(4'h8, 16'h1234);
		rd_reg(4'h8, r);
		`CHK(r, 16'h0000)
		rd_reg(AREA_WAIT_CONFIG_ADDR, r);
		`CHK(r, 16'hA5C3)
		close_out();
	end
endmodule
